// ### verilog/chan_seq_regs.vh
// Contract
// [RULE1] Bit 23 admits slot; reset admits slot zero only
// [RULE2] Start lowest admitted, ascend, wrap to lowest
// [RULE3] Result written loads channel number into status
// [RULE4] Bits 22:20 pick one of eight setups
// [RULE5] Each channel applies its own setup selection
// [RULE6] Bit 19 closes low-side switch for channel
// [RULE7] Power-down forces low-side switch open
// [RULE8] Standby opens switch unless standby allow set
// [RULE9] Slots at register indices 0x09 through 0x18
// [RULE10] Bit 18 enables limit watch if FIFO on
// [RULE11] Switch and setup follow channel being converted
`ifndef CHAN_SEQ_REGS_VH
`define CHAN_SEQ_REGS_VH

// Register indices; byte address is four times the index
`define CTRL_IDX 6'h00
`define STAT_IDX 6'h01
`define SLOT_FIRST_IDX 6'h09
`define SLOT_LAST_IDX 6'h18

// Slot field positions
`define SLOT_EN_BIT 23
`define SLOT_SETUP_HI 22
`define SLOT_SETUP_LO 20
`define SLOT_SW_BIT 19
`define SLOT_WATCH_BIT 18
`define SLOT_WIDTH 24

// Slot reset values
`define SLOT0_RESET 24'h800100
`define SLOTN_RESET 24'h000100

// Control register fields
`define CTRL_RUN_BIT 0
`define CTRL_PM_HI 2
`define CTRL_PM_LO 1
`define CTRL_ALLOW_BIT 3
`define CTRL_RESET 32'h00000000

// Power modes
`define PM_ACTIVE 2'h0
`define PM_STANDBY 2'h1
`define PM_DOWN 2'h2

// Status register fields
`define STAT_CHAN_HI 3
`define STAT_CHAN_LO 0
`define STAT_RUN_BIT 4

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### verilog/channel_pick.v
`timescale 1ns/10ps
// Finds the first admitted slot and the admitted slot after the current one
module channel_pick #(
  parameter SLOTS = 16
) (
  input wire [SLOTS-1:0] i_admit,
  input wire [3:0] i_cur,
  output reg o_any,
  output reg [3:0] o_first,
  output reg [3:0] o_next
);

  // Lowest set bit of a mask at or above a start position
  function [4:0] lowest_from;
    input [SLOTS-1:0] mask;
    input [4:0] start;
    integer k;
    begin
      lowest_from = 5'h10;
      for (k = SLOTS - 1; k >= 0; k = k - 1) begin
        if (mask[k] && (k >= start)) begin
          lowest_from = k[4:0];
        end
      end
    end
  endfunction

  reg [4:0] above; // Next admitted slot strictly above current
  reg [4:0] low;   // Lowest admitted slot overall

  // Ascend from current, wrap to lowest when nothing above
  always @* begin
    low = lowest_from(i_admit, 5'h00);
    above = lowest_from(i_admit, {1'b0, i_cur} + 5'h01);
    o_any = ~low[4];
    o_first = low[3:0];
    if (!above[4]) begin
      o_next = above[3:0]; // [RULE2]
    end else begin
      o_next = low[3:0]; // [RULE2]
    end
  end

endmodule

// ### verilog/channel_sequence_config.v
`timescale 1ns/10ps
`include "chan_seq_regs.vh"
// Channel slot configuration and sequencer with AXI4-Lite register access
module channel_sequence_config #(
  parameter SLOTS = 16,
  parameter ADDR_W = 8
) (
  input wire I_CLK,
  input wire I_RST_N,
  input wire I_CE,
  // AXI4-Lite write address
  input wire [ADDR_W-1:0] I_AWADDR,
  input wire I_AWVALID,
  output wire O_AWREADY,
  // AXI4-Lite write data
  input wire [31:0] I_WDATA,
  input wire [3:0] I_WSTRB,
  input wire I_WVALID,
  output wire O_WREADY,
  // AXI4-Lite write response
  output wire [1:0] O_BRESP,
  output wire O_BVALID,
  input wire I_BREADY,
  // AXI4-Lite read address
  input wire [ADDR_W-1:0] I_ARADDR,
  input wire I_ARVALID,
  output wire O_ARREADY,
  // AXI4-Lite read data
  output wire [31:0] O_RDATA,
  output wire [1:0] O_RRESP,
  output wire O_RVALID,
  input wire I_RREADY,
  // Converter side, same clock domain
  input wire I_CONV_DONE,
  input wire I_FIFO_EN,
  output wire O_SEQ_ACTIVE,
  output wire [3:0] O_CUR_CHAN,
  output wire [2:0] O_SETUP_SEL,
  output wire O_LIMIT_WATCH,
  output wire O_LOW_SIDE_SWITCH_PIN
);

  // Slot storage, one 24-bit word per channel
  reg [`SLOT_WIDTH-1:0] slot_q [0:SLOTS-1];
  reg [31:0] ctrl_q;        // Run, power mode, standby allow
  reg [3:0] stat_chan_q;    // Channel of last written result

  // Write channel holding state
  reg aw_hold_q;
  reg [ADDR_W-1:0] aw_addr_q;
  reg w_hold_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg awready_q;
  reg wready_q;
  reg bvalid_q;
  reg [1:0] bresp_q;

  // Read channel state
  reg arready_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;

  // Sequencer state
  reg run_seen_q;           // Sequence was running last cycle
  reg active_q;             // A channel is being converted
  reg [3:0] cur_q;          // Channel being converted
  reg [2:0] setup_q;        // Setup latched for current channel
  reg sw_req_q;             // Switch bit latched for current channel
  reg watch_req_q;          // Limit watch bit latched for current channel
  reg switch_q;             // Low-side switch drive
  reg watch_q;              // Limit watch drive

  wire [SLOTS-1:0] admit;
  wire pick_any;
  wire [3:0] pick_first;
  wire [3:0] pick_next;

  // Gather admit bits of all slots
  genvar g;
  generate
    for (g = 0; g < SLOTS; g = g + 1) begin : admit_gather
      assign admit[g] = slot_q[g][`SLOT_EN_BIT]; // [RULE1]
    end
  endgenerate

  channel_pick #(
    .SLOTS(SLOTS)
  ) u_pick (
    .i_admit(admit),
    .i_cur(cur_q),
    .o_any(pick_any),
    .o_first(pick_first),
    .o_next(pick_next)
  );

  // Is a word index inside the slot window
  function is_slot;
    input [5:0] idx;
    begin
      is_slot = (idx >= `SLOT_FIRST_IDX) && (idx <= `SLOT_LAST_IDX); // [RULE9]
    end
  endfunction

  // Slot number from a word index
  function [3:0] slot_of;
    input [5:0] idx;
    reg [5:0] diff;
    begin
      diff = idx - `SLOT_FIRST_IDX;
      slot_of = diff[3:0]; // [RULE9]
    end
  endfunction

  // Byte-lane merge of a write into an old word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge[b*8 +: 8] = data[b*8 +: 8];
        end
      end
    end
  endfunction

  wire [5:0] wr_idx = aw_addr_q[7:2];
  wire [5:0] rd_idx = I_ARADDR[7:2];
  // Merged slot word; its top byte is dropped on purpose when stored
  wire [31:0] slot_merged = merge({8'h00, slot_q[slot_of(wr_idx)]},
                                  w_data_q, w_strb_q);
  wire do_write = aw_hold_q && w_hold_q && !bvalid_q;
  wire aw_take = I_AWVALID && awready_q;
  wire w_take = I_WVALID && wready_q;
  wire ar_take = I_ARVALID && arready_q;
  wire run_now = ctrl_q[`CTRL_RUN_BIT] &&
                 (ctrl_q[`CTRL_PM_HI:`CTRL_PM_LO] == `PM_ACTIVE);
  wire [1:0] pmode = ctrl_q[`CTRL_PM_HI:`CTRL_PM_LO];

  // Write address and data are taken independently, either order
  always @(posedge I_CLK) begin
    if (!I_RST_N) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= {ADDR_W{1'b0}};
      w_hold_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else if (I_CE) begin
      if (aw_take) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= I_AWADDR;
      end
      if (w_take) begin
        w_hold_q <= 1'b1;
        w_data_q <= I_WDATA;
        w_strb_q <= I_WSTRB;
      end
      if (do_write) begin
        // Commit and answer; unmapped words get SLVERR
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        if (is_slot(wr_idx) || wr_idx == `CTRL_IDX ||
            wr_idx == `STAT_IDX) begin
          bresp_q <= `RESP_OKAY;
        end else begin
          bresp_q <= `RESP_SLVERR;
        end
      end else if (bvalid_q && I_BREADY) begin
        bvalid_q <= 1'b0;
      end
      // Each ready only while its own channel holds nothing and no response waits
      awready_q <= !(aw_hold_q || aw_take) && !bvalid_q && !do_write;
      wready_q <= !(w_hold_q || w_take) && !bvalid_q && !do_write;
    end
  end

  // Register storage updates on a committed write
  integer s;
  always @(posedge I_CLK) begin
    if (!I_RST_N) begin
      ctrl_q <= `CTRL_RESET;
      for (s = 0; s < SLOTS; s = s + 1) begin
        if (s == 0) begin
          slot_q[s] <= `SLOT0_RESET; // [RULE1]
        end else begin
          slot_q[s] <= `SLOTN_RESET; // [RULE1]
        end
      end
    end else if (I_CE && do_write) begin
      if (is_slot(wr_idx)) begin
        // Bits above 23 are not stored
        slot_q[slot_of(wr_idx)] <= slot_merged[`SLOT_WIDTH-1:0];
      end else if (wr_idx == `CTRL_IDX) begin
        // Only the defined control bits are kept
        ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q) & 32'h0000000f;
      end
    end
  end

  // Read path answers one cycle after the address is taken
  always @(posedge I_CLK) begin
    if (!I_RST_N) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `RESP_OKAY;
    end else if (I_CE) begin
      if (ar_take) begin
        rvalid_q <= 1'b1;
        arready_q <= 1'b0;
        rresp_q <= `RESP_OKAY;
        if (is_slot(rd_idx)) begin
          rdata_q <= {8'h00, slot_q[slot_of(rd_idx)]};
        end else if (rd_idx == `CTRL_IDX) begin
          rdata_q <= ctrl_q;
        end else if (rd_idx == `STAT_IDX) begin
          // Last result channel and running flag
          rdata_q <= {27'h0000000, active_q, stat_chan_q};
        end else begin
          rdata_q <= 32'h00000000;
          rresp_q <= `RESP_SLVERR;
        end
      end else if (rvalid_q && I_RREADY) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end else if (!rvalid_q) begin
        arready_q <= 1'b1;
      end
    end
  end

  // Sequencer: start at lowest admitted, advance on each result
  always @(posedge I_CLK) begin
    if (!I_RST_N) begin
      run_seen_q <= 1'b0;
      active_q <= 1'b0;
      cur_q <= 4'h0;
      setup_q <= 3'h0;
      sw_req_q <= 1'b0;
      watch_req_q <= 1'b0;
      stat_chan_q <= 4'h0;
    end else if (I_CE) begin
      run_seen_q <= run_now;
      if (I_CONV_DONE && active_q) begin
        // Tag the finished result with its channel
        stat_chan_q <= cur_q; // [RULE3]
      end
      if (!run_now || !pick_any) begin
        // Stopped, or nothing admitted: nothing converts
        active_q <= 1'b0;
      end else if (!run_seen_q || !active_q) begin
        // Fresh start always from the lowest admitted slot
        active_q <= 1'b1;
        cur_q <= pick_first; // [RULE2]
        setup_q <= slot_q[pick_first][`SLOT_SETUP_HI:`SLOT_SETUP_LO]; // [RULE4]
        sw_req_q <= slot_q[pick_first][`SLOT_SW_BIT]; // [RULE11]
        watch_req_q <= slot_q[pick_first][`SLOT_WATCH_BIT];
      end else if (I_CONV_DONE) begin
        // Each channel brings its own setup and switch choice
        cur_q <= pick_next; // [RULE2]
        setup_q <= slot_q[pick_next][`SLOT_SETUP_HI:`SLOT_SETUP_LO]; // [RULE5]
        sw_req_q <= slot_q[pick_next][`SLOT_SW_BIT]; // [RULE11]
        watch_req_q <= slot_q[pick_next][`SLOT_WATCH_BIT];
      end
    end
  end

  // Switch and limit watch drives; power modes override the switch at once
  always @(posedge I_CLK) begin
    if (!I_RST_N) begin
      switch_q <= 1'b0;
      watch_q <= 1'b0;
    end else if (I_CE) begin
      watch_q <= active_q && watch_req_q && I_FIFO_EN; // [RULE10]
      case (pmode)
        `PM_DOWN: begin
          switch_q <= 1'b0; // [RULE7]
        end
        `PM_STANDBY: begin
          // Channel bit only counts while standby allow is set
          switch_q <= ctrl_q[`CTRL_ALLOW_BIT] && sw_req_q; // [RULE8]
        end
        `PM_ACTIVE: begin
          switch_q <= active_q && sw_req_q; // [RULE6]
        end
        default: begin
          // Undefined mode is treated as safe: switch open
          switch_q <= 1'b0;
        end
      endcase
    end
  end

  // Outputs straight from flops
  assign O_AWREADY = awready_q;
  assign O_WREADY = wready_q;
  assign O_BVALID = bvalid_q;
  assign O_BRESP = bresp_q;
  assign O_ARREADY = arready_q;
  assign O_RVALID = rvalid_q;
  assign O_RDATA = rdata_q;
  assign O_RRESP = rresp_q;
  assign O_SEQ_ACTIVE = active_q;
  assign O_CUR_CHAN = cur_q;
  assign O_SETUP_SEL = setup_q;
  assign O_LIMIT_WATCH = watch_q;
  assign O_LOW_SIDE_SWITCH_PIN = switch_q;

endmodule

// ### bench/chan_seq_props.sv
`timescale 1ns/10ps
// Port-level checks on the register bus and the slot sequencer
module chan_seq_props #(
  parameter SLOTS = 16,
  parameter ADDR_W = 8
) (
  input wire I_CLK,
  input wire I_RST_N,
  input wire I_CE,
  input wire I_AWVALID,
  input wire O_AWREADY,
  input wire I_WVALID,
  input wire O_WREADY,
  input wire [1:0] O_BRESP,
  input wire O_BVALID,
  input wire I_BREADY,
  input wire I_ARVALID,
  input wire O_ARREADY,
  input wire [31:0] O_RDATA,
  input wire O_RVALID,
  input wire I_RREADY,
  input wire I_CONV_DONE,
  input wire I_FIFO_EN,
  input wire O_SEQ_ACTIVE,
  input wire [3:0] O_CUR_CHAN,
  input wire [2:0] O_SETUP_SEL,
  input wire O_LIMIT_WATCH
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  // Handshake steps of one access
  sequence ar_take; I_CE && I_ARVALID && O_ARREADY; endsequence
  sequence wr_take;
    I_CE && I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
  endsequence
  sequence r_hold; O_RVALID && $stable(O_RDATA); endsequence
  a_read_answer: assert property (ar_take |=> O_RVALID)
    else $error("read reply late");
  a_write_answer: assert property (wr_take |-> ##2 O_BVALID)
    else $error("write reply late");
  a_read_hold: assert property (O_RVALID && !I_RREADY |=> r_hold)
    else $error("read reply dropped");
  a_write_hold: assert property (O_BVALID && !I_BREADY |=>
    O_BVALID && $stable(O_BRESP)) else $error("write reply dropped");
  a_ar_refused: assert property (O_RVALID |-> !O_ARREADY)
    else $error("second read taken");
  // Current slot only moves on a finished conversion
  a_chan_steady: assert property (O_SEQ_ACTIVE && !I_CONV_DONE |=>
    !O_SEQ_ACTIVE || $stable(O_CUR_CHAN)) else $error("channel moved");
  a_setup_steady: assert property (O_SEQ_ACTIVE && !I_CONV_DONE |=>
    !O_SEQ_ACTIVE || $stable(O_SETUP_SEL)) else $error("setup moved");
  a_watch_fifo: assert property (!I_FIFO_EN && I_CE |=>
    !O_LIMIT_WATCH) else $error("watch without fifo");
  a_watch_active: assert property (O_LIMIT_WATCH |->
    $past(O_SEQ_ACTIVE)) else $error("watch while idle");
  // A low clock enable holds the sequencer where it is
  a_ce_freeze: assert property (!I_CE |=> $stable(O_CUR_CHAN) &&
    $stable(O_SETUP_SEL)) else $error("state moved while frozen");
endmodule
bind channel_sequence_config chan_seq_props #(.SLOTS(SLOTS),
  .ADDR_W(ADDR_W)) u_props (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
  .I_CE(I_CE), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY),
  .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BRESP(O_BRESP),
  .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .I_ARVALID(I_ARVALID),
  .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA), .O_RVALID(O_RVALID),
  .I_RREADY(I_RREADY), .I_CONV_DONE(I_CONV_DONE), .I_FIFO_EN(I_FIFO_EN),
  .O_SEQ_ACTIVE(O_SEQ_ACTIVE), .O_CUR_CHAN(O_CUR_CHAN),
  .O_SETUP_SEL(O_SETUP_SEL), .O_LIMIT_WATCH(O_LIMIT_WATCH));

// ### bench/tb_channel_sequence_config.sv
`timescale 1ns/10ps
`include "chan_seq_regs.vh"
// Self-checking bench for the slot sequencer
module tb_channel_sequence_config;
  logic I_CLK = 1'b0;
  logic I_RST_N = 1'b0;
  logic [7:0] I_AWADDR = 8'h00;
  logic [7:0] I_ARADDR = 8'h00;
  logic [31:0] I_WDATA = 32'h0;
  logic I_AWVALID = 1'b0;
  logic I_WVALID = 1'b0;
  logic I_BREADY = 1'b0;
  logic I_ARVALID = 1'b0;
  logic I_RREADY = 1'b0;
  logic I_CONV_DONE = 1'b0;
  logic I_FIFO_EN = 1'b1;
  logic I_CE = 1'b1;
  logic [3:0] I_WSTRB = 4'hf;
  wire O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_SEQ_ACTIVE;
  wire O_LIMIT_WATCH, O_LOW_SIDE_SWITCH_PIN;
  wire [1:0] O_BRESP, O_RRESP;
  wire [31:0] O_RDATA;
  wire [3:0] O_CUR_CHAN;
  wire [2:0] O_SETUP_SEL;
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [1:0] rsp;
  logic [31:0] rd;
  // Clock enable and byte lanes are driven by the scenarios
  channel_sequence_config DUT (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
    .I_CE(I_CE), .I_AWADDR(I_AWADDR), .I_AWVALID(I_AWVALID),
    .O_AWREADY(O_AWREADY), .I_WDATA(I_WDATA), .I_WSTRB(I_WSTRB),
    .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BRESP(O_BRESP),
    .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .I_ARADDR(I_ARADDR),
    .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA),
    .O_RRESP(O_RRESP), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY),
    .I_CONV_DONE(I_CONV_DONE), .I_FIFO_EN(I_FIFO_EN),
    .O_SEQ_ACTIVE(O_SEQ_ACTIVE), .O_CUR_CHAN(O_CUR_CHAN),
    .O_SETUP_SEL(O_SETUP_SEL), .O_LIMIT_WATCH(O_LIMIT_WATCH),
    .O_LOW_SIDE_SWITCH_PIN(O_LOW_SIDE_SWITCH_PIN));
  initial forever #2.5 I_CLK = ~I_CLK;
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge I_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Write: address and data offered together, reply accepted late
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    I_AWADDR <= a;
    I_WDATA <= d;
    I_AWVALID <= 1'b1;
    I_WVALID <= 1'b1;
    while (pa || pw) begin
      @(posedge I_CLK);
      if (O_AWREADY) pa = 1'b0;
      if (O_WREADY) pw = 1'b0;
      I_AWVALID <= pa;
      I_WVALID <= pw;
    end
    @(posedge I_CLK);
    I_BREADY <= 1'b1;
    do @(posedge I_CLK); while (!O_BVALID);
    rsp = O_BRESP;
    I_BREADY <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    I_ARADDR <= a;
    I_ARVALID <= 1'b1;
    do @(posedge I_CLK); while (!O_ARREADY);
    I_ARVALID <= 1'b0;
    @(posedge I_CLK);
    I_RREADY <= 1'b1;
    do @(posedge I_CLK); while (!O_RVALID);
    rd = O_RDATA;
    rsp = O_RRESP;
    I_RREADY <= 1'b0;
  endtask
  // Byte address of a slot
  function automatic logic [7:0] sa(input int i);
    return 8'((`SLOT_FIRST_IDX + i) * 4);
  endfunction
  // Reset values, map edges, write responses and byte lanes
  task automatic t_defaults();
    for (int i = 0; i < 16; i++) begin
      rd_reg(sa(i));
      chk(rd, i == 0 ? 32'h00800100 : 32'h00000100);
    end
    rd_reg(8'h20);
    chk(rsp, `RESP_SLVERR);
    wr(8'h64, 32'hffffffff);
    chk(rsp, `RESP_SLVERR);
    wr(sa(7), 32'hffffffff);
    chk(rsp, `RESP_OKAY);
    rd_reg(sa(7));
    chk(rd, 32'h00ffffff);
    I_WSTRB <= 4'h4;
    wr(sa(7), 32'h00000100);
    I_WSTRB <= 4'hf;
    rd_reg(sa(7));
    chk(rd, 32'h0000ffff);
    wr(sa(7), 32'h00000100);
  endtask
  // One finished conversion, then the next slot's settings
  task automatic step(input int ch, input int su, input logic sw,
                      input int prev);
    I_CONV_DONE <= 1'b1;
    @(posedge I_CLK);
    I_CONV_DONE <= 1'b0;
    repeat (3) @(posedge I_CLK);
    chk(O_CUR_CHAN, ch);
    chk(O_SETUP_SEL, su);
    chk(O_LOW_SIDE_SWITCH_PIN, sw);
    rd_reg(8'h04);
    chk(rd[3:0], prev);
  endtask
  task automatic t_sequence();
    wr(sa(0), 32'h00000100);
    wr(sa(2), 32'h00b80000);
    wr(sa(5), 32'h00e00000);
    wr(sa(9), 32'h009c0000);
    wr(8'h00, 32'h1);
    repeat (3) @(posedge I_CLK);
    chk(O_CUR_CHAN, 2);
    chk(O_SETUP_SEL, 3);
    chk(O_LOW_SIDE_SWITCH_PIN, 1);
    step(5, 6, 1'b0, 2);
    step(9, 1, 1'b1, 5);
    chk(O_LIMIT_WATCH, 1);
    I_FIFO_EN <= 1'b0;
    repeat (3) @(posedge I_CLK);
    chk(O_LIMIT_WATCH, 0);
    I_FIFO_EN <= 1'b1;
    step(2, 3, 1'b1, 9);
  endtask
  // Frozen clock enable: a result pulse must not move the sequencer
  task automatic t_freeze();
    I_CE <= 1'b0;
    I_CONV_DONE <= 1'b1;
    @(posedge I_CLK);
    I_CONV_DONE <= 1'b0;
    repeat (2) @(posedge I_CLK);
    I_CE <= 1'b1;
    chk(O_CUR_CHAN, 2);
    chk(O_SETUP_SEL, 3);
  endtask
  // Power mode change, switch level settled afterwards
  task automatic mode(input logic [31:0] c, input logic e);
    wr(8'h00, c);
    repeat (3) @(posedge I_CLK);
    chk(O_LOW_SIDE_SWITCH_PIN, e);
  endtask
  // Mid-run reset brings back slot defaults and idles the sequencer
  task automatic t_reset();
    I_RST_N <= 1'b0;
    repeat (2) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    @(posedge I_CLK);
    rd_reg(sa(0));
    chk(rd, 32'h00800100);
    rd_reg(sa(2));
    chk(rd, 32'h00000100);
    chk(O_SEQ_ACTIVE, 0);
    chk(O_LOW_SIDE_SWITCH_PIN, 0);
  endtask
  initial begin
    repeat (8) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    @(posedge I_CLK);
    t_defaults();
    t_sequence();
    t_freeze();
    mode(32'h3, 1'b0);
    mode(32'hb, 1'b1);
    mode(32'hd, 1'b0);
    mode(32'hf, 1'b0);
    mode(32'h1, 1'b1);
    chk(O_CUR_CHAN, 2);
    t_reset();
    tally_and_finish();
  end
endmodule
